// ### ctam_ct_model.sv
// partner model: current transformer front end feeding the monitor.
// assumes the bench changes its requests just after a rising edge.
`timescale 1ns/10ps
module ctam_ct_model
    import ctam_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      heat_req,
    input  wire ctam_cur_t load_amp,
    input  wire ctam_cur_t leak_amp,
    output logic           heat_on,
    output ctam_cur_t      cur_sample
);
    // heat state and reading move on one edge, so the pair never disagrees
    always_ff @(posedge clk) begin
        heat_on    <= heat_req;
        cur_sample <= heat_req ? load_amp : leak_amp;
    end
endmodule

// ### ctam_monitor.sv
// load current alarm monitor: samples a current transformer reading,
// splits it into load and leakage current by the heat output state and
// raises low load, leakage and over-current alarms with latching.
// assumes transformer reading and heat output state arrive unsynchronised
// and that the reading holds still for several clocks between updates.
//
// Local design decisions: the placing of the registers and strobed register access.
`include "ctam_params.svh"
`timescale 1ns/10ps
module ctam_monitor
    import ctam_pkg::*;
#(
    parameter logic [15:0] SAMPLE_DIV = `CTAM_SAMPLE_DIV
) (
    input  wire logic        MCLK,
    input  wire logic        NRST,
    input  wire logic [7:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    input  wire logic        HEAT_ON,
    input  wire logic [13:0] CUR_SAMPLE,
    input  wire logic        ALARM_ACK,
    output logic             LOW_LOAD_ALARM_FLAG,
    output logic             LEAKAGE_ALARM_FLAG,
    output logic             OVERCURRENT_ALARM_FLAG,
    output logic             IRQ
);

    // ****************************************************************
    // reset release
    // ****************************************************************
    logic rst_q1;
    logic rst_n;

    // assert at once, release two clocks later so all flops leave together
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // ****************************************************************
    // state and helpers
    // ****************************************************************
    ctam_state_s st_reg;
    ctam_state_s st_next;
    logic [2:0]  act;
    logic [16:0] hprod;
    ctam_cur_t   hyst_val;
    logic        run;
    logic        ack;
    logic [2:0]  w1c;

    // settings beyond full scale are pulled back to it
    function automatic ctam_cur_t ctam_clamp(input logic [15:0] d);
        if (d > `CTAM_FULL_SCALE) begin
            return ctam_cur_t'(`CTAM_FULL_SCALE);
        end
        return d[`CTAM_CUR_BITS];
    endfunction

    function automatic logic ctam_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // margin as a percentage of the transformer range
    assign hprod    = 17'(st_reg.transformer_full_scale) * 17'(st_reg.hys_pct);
    assign hyst_val = ctam_cur_t'(hprod / `CTAM_PCT_DIV);

    // evaluation needs monitoring on and a source channel chosen
    assign run = st_reg.monitor_enable && st_reg.sense_channel_select != '0;

    // register strobe or a fresh rising edge on the pin
    assign ack = (WR && ctam_hit(ADDR, `CTAM_OFF_ACK) && WDATA[`CTAM_ACK_BIT])
               || (st_reg.ack_s2 && !st_reg.ack_s3);

    assign w1c = (WR && ctam_hit(ADDR, `CTAM_OFF_IRQ_STAT))
               ? WDATA[`CTAM_FLAG_BITS] : 3'h0;

    // ****************************************************************
    // threshold comparators: 0 low load, 1 leakage, 2 over-current
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_cmp
            ctam_thr_cmp #(
                .W         (14)
            ) u_cmp (
                .clk       (MCLK),
                .rst_n     (rst_n),
                .run       (run),
                .high_side (gi != 0),
                .value     ((gi == 1) ? st_reg.measured_leak_current
                                      : st_reg.load_cur),
                .thr       (st_reg.thr[gi]),
                .hyst      (hyst_val),
                .active    (act[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_next       = st_reg;
        st_next.rdata = '0;

        // two-stage synchronisers on the heat, sample and acknowledge pin inputs
        st_next.heat_s1 = HEAT_ON;
        st_next.heat_s2 = st_reg.heat_s1;
        st_next.samp_s1 = CUR_SAMPLE;
        st_next.samp_s2 = st_reg.samp_s1;
        st_next.ack_s1  = ALARM_ACK;
        st_next.ack_s2  = st_reg.ack_s1;
        st_next.ack_s3  = st_reg.ack_s2;

        // sample enable divider
        st_next.tick = 1'b0;
        if (st_reg.div_cnt == SAMPLE_DIV - 16'h0001) begin
            st_next.div_cnt = '0;
            st_next.tick    = 1'b1;
        end else begin
            st_next.div_cnt = st_reg.div_cnt + 16'h0001;
        end

        // split the reading by heat output state
        if (st_reg.tick) begin
            if (st_reg.heat_s2) begin
                st_next.load_cur = st_reg.samp_s2;
            end else begin
                st_next.measured_leak_current = st_reg.samp_s2;
            end
        end

        // register writes; illegal source and latch codes keep the old value, hysteresis clamps
        if (WR) begin
            case (ADDR)
                `CTAM_OFF_CTRL: begin
                    st_next.monitor_enable = WDATA[`CTAM_CTRL_EN];
                    if (WDATA[`CTAM_CTRL_SRC] <= `CTAM_SRC_MAX) begin
                        st_next.sense_channel_select = WDATA[`CTAM_CTRL_SRC];
                    end
                    if (WDATA[`CTAM_CTRL_LAT] <= `CTAM_LAT_MAX) begin
                        st_next.alarm_latch_mode =
                            ctam_latch_e'(WDATA[`CTAM_CTRL_LAT]);
                    end
                    st_next.hys_pct = (WDATA[`CTAM_CTRL_HYS] > `CTAM_HYS_MAX)
                                    ? `CTAM_HYS_MAX : WDATA[`CTAM_CTRL_HYS];
                end
                `CTAM_OFF_RANGE: begin
                    st_next.transformer_full_scale = ctam_clamp(WDATA);
                end
                `CTAM_OFF_THR_LOW: begin
                    st_next.thr[0] = ctam_clamp(WDATA);
                end
                `CTAM_OFF_THR_LEAK: begin
                    st_next.thr[1] = ctam_clamp(WDATA);
                end
                `CTAM_OFF_THR_OC: begin
                    st_next.thr[2] = ctam_clamp(WDATA);
                end
                `CTAM_OFF_IRQ_MASK: begin
                    st_next.mask = WDATA[`CTAM_FLAG_BITS];
                end
                default: begin
                end
            endcase
        end

        // latching per alarm; in auto and manual mode a new condition beats a clear
        for (int i = 0; i < 3; i++) begin
            case (st_reg.alarm_latch_mode)
                CTAM_LAT_NONE: begin
                    st_next.flag[i] = act[i] && !ack;
                    st_next.pend[i] = 1'b0;
                end
                CTAM_LAT_AUTO: begin
                    // ack may come early; the flag drops once the cause is gone
                    st_next.pend[i] = (st_reg.pend[i] || ack) && act[i];
                    st_next.flag[i] = act[i]
                                    || (st_reg.flag[i] && !(st_reg.pend[i] || ack));
                end
                CTAM_LAT_MAN: begin
                    // ack only counts once the cause has gone
                    st_next.flag[i] = (st_reg.flag[i] && !(ack && !act[i])) || act[i];
                    st_next.pend[i] = 1'b0;
                end
                default: begin
                    st_next.flag[i] = 1'b0;
                    st_next.pend[i] = 1'b0;
                end
            endcase
        end
        if (!run) begin
            st_next.flag = '0;
            st_next.pend = '0;
        end

        // sticky events on each new alarm; the set wins over write-one-clear
        st_next.stat = (st_reg.stat & ~w1c) | (st_next.flag & ~st_reg.flag);

        // read data for exactly the cycle after the strobe
        if (RD) begin
            case (ADDR)
                `CTAM_OFF_CTRL: begin
                    st_next.rdata[`CTAM_CTRL_EN]  = st_reg.monitor_enable;
                    st_next.rdata[`CTAM_CTRL_SRC] = st_reg.sense_channel_select;
                    st_next.rdata[`CTAM_CTRL_LAT] = st_reg.alarm_latch_mode;
                    st_next.rdata[`CTAM_CTRL_HYS] = st_reg.hys_pct;
                end
                // range and thresholds read as zero while monitoring is off
                `CTAM_OFF_RANGE: begin
                    if (st_reg.monitor_enable) begin
                        st_next.rdata[`CTAM_CUR_BITS] = st_reg.transformer_full_scale;
                    end
                end
                `CTAM_OFF_THR_LOW: begin
                    if (st_reg.monitor_enable) begin
                        st_next.rdata[`CTAM_CUR_BITS] = st_reg.thr[0];
                    end
                end
                `CTAM_OFF_THR_LEAK: begin
                    if (st_reg.monitor_enable) begin
                        st_next.rdata[`CTAM_CUR_BITS] = st_reg.thr[1];
                    end
                end
                `CTAM_OFF_THR_OC: begin
                    if (st_reg.monitor_enable) begin
                        st_next.rdata[`CTAM_CUR_BITS] = st_reg.thr[2];
                    end
                end
                `CTAM_OFF_LOAD: begin
                    st_next.rdata[`CTAM_CUR_BITS] = st_reg.load_cur;
                end
                `CTAM_OFF_LEAK: begin
                    st_next.rdata[`CTAM_CUR_BITS] = st_reg.measured_leak_current;
                end
                `CTAM_OFF_FLAGS: begin
                    st_next.rdata[`CTAM_FLAG_BITS] = st_reg.flag;
                end
                `CTAM_OFF_IRQ_STAT: begin
                    st_next.rdata[`CTAM_FLAG_BITS] = st_reg.stat;
                end
                `CTAM_OFF_IRQ_MASK: begin
                    st_next.rdata[`CTAM_FLAG_BITS] = st_reg.mask;
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            st_reg                        <= '0;
            st_reg.transformer_full_scale <= `CTAM_RST_RANGE;
            st_reg.hys_pct                <= `CTAM_RST_HYS;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs
    assign RDATA                  = st_reg.rdata;
    assign LOW_LOAD_ALARM_FLAG    = st_reg.flag[0];
    assign LEAKAGE_ALARM_FLAG     = st_reg.flag[1];
    assign OVERCURRENT_ALARM_FLAG = st_reg.flag[2];
    assign IRQ                    = |(st_reg.stat & st_reg.mask);

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!rst_n);

    sequence s_tick_on;
        st_reg.tick && st_reg.heat_s2;
    endsequence

    sequence s_tick_off;
        st_reg.tick && !st_reg.heat_s2;
    endsequence

    load_capture_a: assert property (s_tick_on |=> st_reg.load_cur == $past(st_reg.samp_s2))
        else $error("load current not captured while heat on");

    leak_capture_a: assert property (s_tick_off |=> (st_reg.measured_leak_current
        == $past(st_reg.samp_s2)) && $stable(st_reg.load_cur))
        else $error("leakage current not captured while heat off");

    low_alarm_a: assert property ((run && st_reg.alarm_latch_mode == CTAM_LAT_NONE && !ack
        && st_reg.thr[0] != '0 && st_reg.load_cur < st_reg.thr[0])[*2] |=> st_reg.flag[0])
        else $error("low load alarm missing");

    leak_alarm_a: assert property ((run && st_reg.alarm_latch_mode == CTAM_LAT_NONE && !ack
        && st_reg.thr[1] != '0
        && st_reg.measured_leak_current > st_reg.thr[1])[*2] |=> st_reg.flag[1])
        else $error("leakage alarm missing");

    oc_alarm_a: assert property ((run && st_reg.alarm_latch_mode == CTAM_LAT_NONE && !ack
        && st_reg.thr[2] != '0 && st_reg.load_cur > st_reg.thr[2])[*2] |=> st_reg.flag[2])
        else $error("over-current alarm missing");

    oc_hyst_hold_a: assert property (act[2] && run && st_reg.thr[2] != '0
        && 15'(st_reg.load_cur) + 15'(hyst_val) > 15'(st_reg.thr[2]) |=> act[2])
        else $error("over-current released inside hysteresis band");

    off_quiet_a: assert property (!run |=> st_reg.flag == '0 ##1 st_reg.flag == '0)
        else $error("alarm raised while monitoring idle");

    manual_ack_a: assert property (st_reg.alarm_latch_mode == CTAM_LAT_MAN && run && ack
        && act == '0 |=> st_reg.flag == '0)
        else $error("acknowledge did not clear alarms");
    auto_set_a: assert property (run && st_reg.alarm_latch_mode == CTAM_LAT_AUTO && act[2]
        |=> st_reg.flag[2]) else $error("auto latch dropped an active alarm");

    hidden_read_a: assert property (RD && !st_reg.monitor_enable
        && ADDR == `CTAM_OFF_RANGE |=> RDATA == '0)
        else $error("setting visible while monitoring disabled");

    load_read_a: assert property (RD && ADDR == `CTAM_OFF_LOAD
        |=> RDATA[`CTAM_CUR_BITS] == $past(st_reg.load_cur) ##1 RDATA == '0 || $past(RD))
        else $error("load current read back wrong");

endmodule

// ### ctam_params.svh
// constants of the load current alarm monitor: register offsets,
// field positions, reset values and timing counts.
// assumes inclusion by bare name from every design file that needs it.
`ifndef CTAM_PARAMS_SVH
`define CTAM_PARAMS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CTAM_OFF_CTRL      8'h00
`define CTAM_OFF_RANGE     8'h04
`define CTAM_OFF_THR_LOW   8'h08
`define CTAM_OFF_THR_LEAK  8'h0C
`define CTAM_OFF_THR_OC    8'h10
`define CTAM_OFF_LOAD      8'h14
`define CTAM_OFF_LEAK      8'h18
`define CTAM_OFF_FLAGS     8'h1C
`define CTAM_OFF_IRQ_STAT  8'h20
`define CTAM_OFF_IRQ_MASK  8'h24
`define CTAM_OFF_ACK       8'h28

// ****************************************************************
// control word and register fields
// ****************************************************************
`define CTAM_CTRL_EN       0
`define CTAM_CTRL_SRC      3:1
`define CTAM_CTRL_LAT      5:4
`define CTAM_CTRL_HYS      10:8
`define CTAM_ACK_BIT       0
`define CTAM_CUR_BITS      13:0
`define CTAM_FLAG_BITS     2:0

// ****************************************************************
// values, limits and counts (currents in tenths of a unit)
// ****************************************************************
`define CTAM_RST_RANGE     14'h03E8
`define CTAM_RST_HYS       3'h2
`define CTAM_HYS_MAX       3'h5
`define CTAM_SRC_MAX       3'h4
`define CTAM_LAT_MAX       2'h2
`define CTAM_FULL_SCALE    16'h2710
`define CTAM_PCT_DIV       17'h00064
`define CTAM_SAMPLE_DIV    16'h0064

`endif

// ### ctam_pkg.sv
// types shared by the load current alarm monitor modules.
// assumes nothing beyond a SystemVerilog compiler.
package ctam_pkg;

    typedef logic [13:0] ctam_cur_t;

    // encoding follows declaration order: none, auto reset, manual reset
    typedef enum logic [1:0] {
        CTAM_LAT_NONE,
        CTAM_LAT_AUTO,
        CTAM_LAT_MAN
    } ctam_latch_e;

    typedef struct packed {
        logic active;
    } ctam_cmp_s;

    typedef struct packed {
        logic                 monitor_enable;
        logic [2:0]           sense_channel_select;
        ctam_latch_e          alarm_latch_mode;
        logic [2:0]           hys_pct;
        ctam_cur_t            transformer_full_scale;
        ctam_cur_t [2:0]      thr;
        ctam_cur_t            load_cur;
        ctam_cur_t            measured_leak_current;
        logic                 heat_s1;
        logic                 heat_s2;
        ctam_cur_t            samp_s1;
        ctam_cur_t            samp_s2;
        logic                 ack_s1;
        logic                 ack_s2;
        logic                 ack_s3;
        logic [15:0]          div_cnt;
        logic                 tick;
        logic [2:0]           flag;
        logic [2:0]           pend;
        logic [2:0]           stat;
        logic [2:0]           mask;
        logic [15:0]          rdata;
    } ctam_state_s;

endpackage

// ### ctam_thr_cmp.sv
// threshold comparator with hysteresis for one alarm condition.
// assumes value, threshold and margin are steady registers on clk.
`timescale 1ns/10ps
module ctam_thr_cmp
    import ctam_pkg::*;
#(
    parameter int W = 14
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         run,
    input  wire logic         high_side,
    input  wire logic [W-1:0] value,
    input  wire logic [W-1:0] thr,
    input  wire logic [W-1:0] hyst,
    output logic              active
);

    ctam_cmp_s  st_reg;
    ctam_cmp_s  st_next;
    logic [W:0] v;
    logic [W:0] t;
    logic [W:0] h;

    // one extra bit so sums of value and margin cannot wrap
    assign v = {1'b0, value};
    assign t = {1'b0, thr};
    assign h = {1'b0, hyst};

    // set beyond the threshold, release only past it by the margin
    always_comb begin
        st_next = st_reg;
        if (!run || thr == '0) begin
            st_next.active = 1'b0;
        end else if (high_side) begin
            if (v > t) begin
                st_next.active = 1'b1;
            end else if (v + h <= t) begin
                st_next.active = 1'b0;
            end
        end else begin
            if (v < t) begin
                st_next.active = 1'b1;
            end else if (v >= t + h) begin
                st_next.active = 1'b0;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign active = st_reg.active;

endmodule

// ### tb_load_current_alarm_monitor.sv
// testbench of the load current alarm monitor against an integer model.
// assumes the monitor is built with a sample divider of 4 clocks.
`include "ctam_params.svh"
`timescale 1ns/10ps
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin n_mismatch++; \
    $display("BAD %0t got %h want %h", $time, act, exp); end end
module tb_load_current_alarm_monitor
    import ctam_pkg::*;
;
    logic        MCLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0, ALARM_ACK = 1'b0;
    logic        heat_req = 1'b0, HEAT_ON, IRQ;
    logic [7:0]  ADDR = 8'h00;
    logic [15:0] WDATA = 16'h0000, RDATA, lfsr = 16'hB62A;
    ctam_cur_t   load_amp = 14'h0000, leak_amp = 14'h0000, CUR_SAMPLE;
    wire  [2:0]  flags;
    int          n_mismatch = 0, num_checks = 0, rng = 1000, hys = 2, mode = 0, ld = 0, lk = 0;
    int          thr[3] = '{0, 0, 0};
    int          seq[9] = '{499, 510, 520, 2001, 1990, 1980, -101, -81, -80};
    bit   [2:0]  c = 0, acked = 0, fm = 0, stat = 0, mask = 0;

    // free running 10 MHz clock
    always #50 MCLK = ~MCLK;

    ctam_monitor #(.SAMPLE_DIV(16'h0004)) ctam_monitor_i (
        .MCLK(MCLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .HEAT_ON(HEAT_ON), .CUR_SAMPLE(CUR_SAMPLE), .ALARM_ACK(ALARM_ACK),
        .LOW_LOAD_ALARM_FLAG(flags[0]), .LEAKAGE_ALARM_FLAG(flags[1]),
        .OVERCURRENT_ALARM_FLAG(flags[2]), .IRQ(IRQ));
    ctam_ct_model ctam_ct_model_i (
        .clk(MCLK), .heat_req(heat_req), .load_amp(load_amp), .leak_amp(leak_amp),
        .heat_on(HEAT_ON), .cur_sample(CUR_SAMPLE));

    // ****************************************************************
    // model and bus helpers
    // ****************************************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // hysteresis only widens the exit side, entry stays at the bare threshold
    function automatic bit cmp(input bit act, input int v, input int t, input bit low);
        int h;
        h = rng * hys / 100;
        if (t == 0) return 1'b0;
        if (low) return act ? (v < t + h) : (v < t);
        return act ? (v + h > t) : (v > t);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge MCLK);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge MCLK);
        WR    <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        @(posedge MCLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge MCLK);
        RD   <= 1'b0;
        @(negedge MCLK);
        `CHK(RDATA, e)
    endtask

    // one steady reading, long enough for sync, a tick and the flag stage
    task automatic step(input bit on, input int amp);
        bit [2:0] old;
        @(posedge MCLK);
        heat_req <= on;
        if (on) load_amp <= 14'(amp);
        else leak_amp <= 14'(amp);
        repeat (14) @(posedge MCLK);
        if (on) ld = amp;
        else lk = amp;
        c[2] = cmp(c[2], ld, thr[2], 1'b0);
        c[1] = cmp(c[1], lk, thr[1], 1'b0);
        c[0] = cmp(c[0], ld, thr[0], 1'b1);
        old = fm;
        fm = (mode == 0) ? c : (fm | c);
        fm = fm & ~(acked & ~c & {3{mode == 1}});
        acked = acked & fm;
        stat = stat | (fm & ~old);
        @(negedge MCLK);
        `CHK(flags, fm)
        `CHK(IRQ, |(stat & mask))
        rd_chk(`CTAM_OFF_LOAD, 16'(ld));
        rd_chk(`CTAM_OFF_LEAK, 16'(lk));
        rd_chk(`CTAM_OFF_IRQ_STAT, 16'(stat));
        wr(`CTAM_OFF_IRQ_STAT, 16'h0007);
        stat = 3'b000;
    endtask

    // acknowledge by pin or by register write
    task automatic ack(input bit pin);
        if (pin) begin
            @(posedge MCLK);
            ALARM_ACK <= 1'b1;
            repeat (4) @(posedge MCLK);
            ALARM_ACK <= 1'b0;
        end else begin
            wr(`CTAM_OFF_ACK, 16'h0001);
        end
        repeat (6) @(posedge MCLK);
        acked = acked | (c & fm & {3{mode == 1}});
        fm = fm & c;
        acked = acked & fm;
        @(negedge MCLK);
        `CHK(flags, fm)
    endtask

    task automatic close_out();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (4) @(posedge MCLK);
        NRST <= 1'b1;
        repeat (3) @(posedge MCLK);
        rd_chk(`CTAM_OFF_CTRL, 16'h0200);
        rd_chk(`CTAM_OFF_RANGE, 16'h0000);
        rd_chk(8'h30, 16'h0000);
        wr(`CTAM_OFF_CTRL, 16'h0203);
        rd_chk(`CTAM_OFF_RANGE, 16'h03E8);
        step(1'b1, 0);
        thr = '{500, 100, 2000};
        wr(`CTAM_OFF_THR_LOW, 16'h01F4);
        wr(`CTAM_OFF_THR_LEAK, 16'h0064);
        wr(`CTAM_OFF_THR_OC, 16'h07D0);
        rd_chk(`CTAM_OFF_THR_OC, 16'h07D0);
        mask = 3'b101;
        wr(`CTAM_OFF_IRQ_MASK, 16'h0005);
        foreach (seq[i]) step(seq[i] > 0, (seq[i] < 0) ? -seq[i] : seq[i]);
        repeat (16) begin
            lfsr = lfsr_next(lfsr);
            step(lfsr[15], int'(lfsr[11:0]) % 2600);
        end
        // both latching modes: clear with condition gone, ack while active
        for (int m = 1; m < 3; m++) begin
            mode = m;
            // source channel 2 in auto mode, 4 in manual mode
            wr(`CTAM_OFF_CTRL, 16'(16'h0201 | (m << 4) | (m << 2)));
            step(1'b1, 2500);
            step(1'b1, 1000);
            ack(1'b0);
            step(1'b1, 2500);
            ack(1'b1);
            step(1'b1, 1000);
            ack(1'b0);
        end
        // source 5 and latch code 3 are refused, hysteresis above 5 clamps
        wr(`CTAM_OFF_CTRL, 16'h073B);
        rd_chk(`CTAM_OFF_CTRL, 16'h0529);
        hys = 5;
        step(1'b1, 2500);
        wr(`CTAM_OFF_CTRL, 16'h0521);
        repeat (4) @(posedge MCLK);
        @(negedge MCLK);
        `CHK(flags, 3'b000)
        close_out();
    end

    // watchdog well beyond the expected run of about 900 clocks
    initial begin
        #1000000;
        n_mismatch++;
        close_out();
    end
endmodule
